// file: rtl/bfg_pkg.sv
package bfg_pkg;

  // ---------------------------------------------------------------
  // flash geometry (word addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 14;
  localparam logic [13:0] HALT_REGION_LO  = 14'h3800;  // halting region start
  localparam logic [13:0] APP_RESET_ADDR  = 14'h0000;
  // loader region start per boot-size fuse code
  localparam logic [13:0] LOADER_LO_0     = 14'h3800;
  localparam logic [13:0] LOADER_LO_1     = 14'h3c00;
  localparam logic [13:0] LOADER_LO_2     = 14'h3e00;
  localparam logic [13:0] LOADER_LO_3     = 14'h3f00;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;  // read enable, program, chip erase
  localparam logic [7:0] REG_STATUS = 8'h04;  // busy, halt, op active
  localparam logic [7:0] REG_LOCK   = 8'h08;  // lock bits
  localparam logic [7:0] REG_FUSE   = 8'h0c;  // fuse view, read only

  // ctrl bit positions
  localparam int CTRL_RE_BIT     = 0;  // concurrent_region_read_enable
  localparam int CTRL_LOCK_BIT   = 1;  // program lock bits from wdata[11:8]
  localparam int CTRL_ERASE_BIT  = 2;  // chip erase (programming interface)
  localparam int CTRL_EXTPRG_BIT = 3;  // access from programming interface

  // status bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_HALT_BIT = 1;
  localparam int ST_OP_BIT   = 2;

  localparam logic [3:0]  LOCK_RESET = 4'hf;      // all unprogrammed
  localparam int          LOCK_LSB   = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [1:0]  RESP_DECERR = 2'b11;

  // lock modes as bit pairs {high, low}
  localparam logic [1:0] LOCK_M1 = 2'b11;
  localparam logic [1:0] LOCK_M2 = 2'b10;
  localparam logic [1:0] LOCK_M3 = 2'b00;
  localparam logic [1:0] LOCK_M4 = 2'b01;

  typedef enum logic [1:0] {
    BFG_OP_NONE,
    BFG_OP_ERASE,
    BFG_OP_WRITE,
    BFG_OP_BUFFER
  } bfg_op_t;

endpackage : bfg_pkg

// file: rtl/bfg_guard.sv
`timescale 1ns/1ps
// Function
// - concurrent region programming: only halting region readable, cpu keeps running
// - busy flag reads one while concurrent region is blocked
// - loader region always lies inside halting region
// - halting region programming stalls cpu; nothing readable meanwhile
// - lock bits only programmed by software; cleared only by chip erase; here reset also reloads LOCK_RESET
// - general write lock does not affect store programming
// - general read/write lock does not restrict load or store
// - application lock mode 1: no restriction
// - application lock mode 2: store writes to application blocked
// - application mode 3: store blocked, loader loads from application blocked
// - application mode 4: loader loads from application blocked, stores allowed
// - application modes 3,4 with loader vectors: suppress irq in application
// - loader lock mode 1: no restriction
// - loader lock mode 2: store writes to loader blocked
// - loader mode 3: store blocked, application loads from loader blocked
// - loader mode 4: application loads from loader blocked, stores allowed
// - loader modes 3,4 with application vectors: suppress irq in loader
// - boot reset fuse 1 starts at 0x0000, 0 at loader reset
// - cpu cannot alter fuses
// - boot size fuses set the region boundary
// - store ignored when executed from application region
// - writing read enable once no operation is in progress clears busy flag and releases region
module bfg_guard
  import bfg_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // fuses, strapped at the pins
  input  wire logic                 boot_reset_select_fuse,
  input  wire logic [1:0]           boot_size_fuses,
  input  wire logic                 general_lock_write,
  input  wire logic                 general_lock_rw,
  // cpu access port
  input  wire logic [bfg_pkg::ADDR_W-1:0] pc_addr,
  input  wire logic                 acc_valid,
  input  wire logic                 acc_store,
  input  wire logic [bfg_pkg::ADDR_W-1:0] acc_addr,
  input  wire logic                 fetch_valid,
  input  wire logic [bfg_pkg::ADDR_W-1:0] fetch_addr,
  input  wire logic                 vectors_in_loader,
  input  wire logic                 irq_req,
  // flash programming engine
  input  wire logic                 flash_done,
  output logic                      acc_grant,
  output logic                      acc_deny,
  output logic                      fetch_grant,
  output logic                      prog_start,
  output logic [bfg_pkg::ADDR_W-1:0] prog_addr,
  output logic                      cpu_halt,
  output logic                      irq_out,
  output logic [bfg_pkg::ADDR_W-1:0] reset_vector,
  // axi4-lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        lock;
    logic              busy;
    logic              halt;
    bfg_op_t           op;
    logic              acc_grant;
    logic              acc_deny;
    logic              fetch_grant;
    logic              prog_start;
    logic [ADDR_W-1:0] prog_addr;
    logic              irq_out;
    logic [ADDR_W-1:0] reset_vector;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              started;
    logic              awready;
    logic              wready;
    logic              arready;
  } bfg_state_t;

  bfg_state_t s;
  bfg_state_t next_s;

  // ---------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] loader_lo;
  logic              pc_in_loader;
  logic              tgt_in_loader;
  logic              tgt_in_halt;
  logic              fetch_in_halt;
  logic [1:0]        app_mode;
  logic [1:0]        ldr_mode;
  logic              app_ld_block;
  logic              ldr_ld_block;
  logic              store_block;
  logic              load_block;
  logic              read_blocked;

  always_comb
  begin
    // every loader start is at or above the halting region start
    if (boot_size_fuses == 2'b11)
      loader_lo = LOADER_LO_3;
    else if (boot_size_fuses == 2'b10)
      loader_lo = LOADER_LO_2;
    else if (boot_size_fuses == 2'b01)
      loader_lo = LOADER_LO_1;
    else
      loader_lo = LOADER_LO_0;
  end

  assign pc_in_loader  = (pc_addr >= loader_lo);
  assign tgt_in_loader = (acc_addr >= loader_lo);
  assign tgt_in_halt   = (acc_addr >= HALT_REGION_LO);
  assign fetch_in_halt = (fetch_addr >= HALT_REGION_LO);
  assign app_mode      = s.lock[1:0];
  assign ldr_mode      = s.lock[3:2];

  // general lock inputs deliberately do not enter these terms
  assign app_ld_block = pc_in_loader && !tgt_in_loader
                        && (app_mode == LOCK_M3 || app_mode == LOCK_M4);
  assign ldr_ld_block = !pc_in_loader && tgt_in_loader
                        && (ldr_mode == LOCK_M3 || ldr_mode == LOCK_M4);
  always_comb
  begin
    store_block = 1'b0;
    if (!pc_in_loader)
      store_block = 1'b1;
    else if (tgt_in_loader)
      store_block = (ldr_mode == LOCK_M2) || (ldr_mode == LOCK_M3);
    else
      store_block = (app_mode == LOCK_M2) || (app_mode == LOCK_M3);
  end
  assign load_block   = app_ld_block || ldr_ld_block;
  // halting region op blocks everything; concurrent op blocks its own region
  assign read_blocked = s.halt || (s.busy && !tgt_in_halt);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic rd_go;
  logic wr_hit;

  assign aw_take = s_axi_awvalid && !s.aw_got && !s.bvalid;
  assign w_take  = s_axi_wvalid && !s.w_got && !s.bvalid;
  assign wr_go   = (s.aw_got || aw_take) && (s.w_got || w_take) && !s.bvalid;
  assign rd_go   = s_axi_arvalid && !s.rvalid;

  always_comb
  begin
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        prog_req;
    wa       = aw_take ? s_axi_awaddr : s.awaddr;
    wd       = w_take ? s_axi_wdata : s.wdata;
    ws       = w_take ? s_axi_wstrb : s.wstrb;
    prog_req = 1'b0;
    next_s = s;
    wr_hit = 1'b0;
    next_s.prog_start = 1'b0;
    next_s.started = 1'b1;
    // reset vector sampled once after reset release
    if (!s.started)
      next_s.reset_vector = boot_reset_select_fuse ? APP_RESET_ADDR : loader_lo;

    // cpu access check
    next_s.acc_grant = 1'b0;
    next_s.acc_deny  = 1'b0;
    if (acc_valid && !acc_store)
    begin
      next_s.acc_grant = !load_block && !read_blocked;
      next_s.acc_deny  = load_block;
    end
    else if (acc_valid && acc_store)
    begin
      if (store_block)
        next_s.acc_deny = 1'b1;
      else if (s.op == BFG_OP_NONE)
      begin
        next_s.acc_grant = 1'b1;
        prog_req         = 1'b1;
      end
    end
    next_s.fetch_grant = fetch_valid && !s.halt && !(s.busy && !fetch_in_halt);

    if (prog_req)
    begin
      next_s.op         = BFG_OP_WRITE;
      next_s.prog_start = 1'b1;
      next_s.prog_addr  = acc_addr;
      if (tgt_in_halt)
        next_s.halt = 1'b1;
      else
        next_s.busy = 1'b1;
    end
    else if (flash_done && s.op != BFG_OP_NONE)
    begin
      next_s.op   = BFG_OP_NONE;
      next_s.halt = 1'b0;
    end

    // register writes
    next_s.awaddr = wa;
    next_s.wdata  = wd;
    next_s.wstrb  = ws;
    if (aw_take)
      next_s.aw_got = 1'b1;
    if (w_take)
      next_s.w_got = 1'b1;
    if (wr_go)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      if (wa == REG_CTRL)
      begin
        wr_hit = ws[0];
        if (ws[0] && wd[CTRL_RE_BIT] && s.op == BFG_OP_NONE && !prog_req)
          next_s.busy = 1'b0;
        if (ws[1] && wd[CTRL_LOCK_BIT] && pc_in_loader)
          next_s.lock = s.lock & wd[LOCK_LSB +: 4];
        if (ws[0] && wd[CTRL_ERASE_BIT] && wd[CTRL_EXTPRG_BIT])
          next_s.lock = LOCK_RESET;
      end
      else if (wa == REG_STATUS || wa == REG_LOCK || wa == REG_FUSE)
        next_s.bresp = RESP_SLVERR;
      else
        next_s.bresp = RESP_DECERR;
    end
    else if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    // ready flops mirror the next hold state so the pins stay registered
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;

    // register reads
    if (rd_go)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      if (s_axi_araddr == REG_CTRL)
        next_s.rdata = 32'h0000_0000;
      else if (s_axi_araddr == REG_STATUS)
      begin
        next_s.rdata[ST_BUSY_BIT] = s.busy;
        next_s.rdata[ST_HALT_BIT] = s.halt;
        next_s.rdata[ST_OP_BIT]   = (s.op != BFG_OP_NONE);
      end
      else if (s_axi_araddr == REG_LOCK)
        next_s.rdata[LOCK_LSB +: 4] = s.lock;
      else if (s_axi_araddr == REG_FUSE)
        next_s.rdata[2:0] = {boot_size_fuses, boot_reset_select_fuse};
      else
        next_s.rresp = RESP_DECERR;
    end
    else if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    next_s.arready = !next_s.rvalid;

    // interrupt suppression by vector placement and while the cpu is halted
    next_s.irq_out = irq_req;
    if (vectors_in_loader && !pc_in_loader
        && (app_mode == LOCK_M3 || app_mode == LOCK_M4))
      next_s.irq_out = 1'b0;
    if (!vectors_in_loader && pc_in_loader
        && (ldr_mode == LOCK_M3 || ldr_mode == LOCK_M4))
      next_s.irq_out = 1'b0;
    if (s.halt)
      next_s.irq_out = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s              <= '0;
      s.lock         <= LOCK_RESET;
      s.op           <= BFG_OP_NONE;
      s.reset_vector <= APP_RESET_ADDR;
      s.awready      <= 1'b1;
      s.wready       <= 1'b1;
      s.arready      <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign acc_grant     = s.acc_grant;
  assign acc_deny      = s.acc_deny;
  assign fetch_grant   = s.fetch_grant;
  assign prog_start    = s.prog_start;
  assign prog_addr     = s.prog_addr;
  assign cpu_halt      = s.halt;
  assign irq_out       = s.irq_out;
  assign reset_vector  = s.reset_vector;
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence store_to_halt_s;
    acc_valid && acc_store && !store_block && s.op == BFG_OP_NONE && tgt_in_halt;
  endsequence

  halt_on_halting_region_a: assert property (@(posedge clk) disable iff (!rst_n)
    store_to_halt_s |=> cpu_halt && !fetch_grant)
    else $error("halting region store did not halt cpu");

  busy_on_rww_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_valid && acc_store && !store_block && s.op == BFG_OP_NONE && !tgt_in_halt
    |=> s.busy && !cpu_halt)
    else $error("concurrent region store did not set busy");

  fetch_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    s.busy && fetch_valid && !fetch_in_halt |=> !fetch_grant)
    else $error("fetch from blocked concurrent region granted");

  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    s.busy && !(wr_go && wr_hit) |=> s.busy)
    else $error("busy flag dropped without read enable write");

  app_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_valid && acc_store && !pc_in_loader |=> acc_deny && !prog_start)
    else $error("store from application region not ignored");

  lock_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.lock & ~$past(s.lock)) == 4'h0 || s.lock == LOCK_RESET)
    else $error("lock bit cleared without chip erase");

  ldr_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_valid && !acc_store && !pc_in_loader && tgt_in_loader && ldr_mode == LOCK_M3
    |=> acc_deny && !acc_grant)
    else $error("application load from locked loader allowed");

  app_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    vectors_in_loader && !pc_in_loader && app_mode == LOCK_M4 |=> !irq_out)
    else $error("interrupt not suppressed in application region");

  rst_vec_a: assert property (@(posedge clk)
    $rose(s.started) |-> reset_vector == (boot_reset_select_fuse ? APP_RESET_ADDR : loader_lo)
                          || $past(boot_reset_select_fuse) != boot_reset_select_fuse)
    else $error("reset vector does not follow fuse");

endmodule : bfg_guard

// file: dv/bfg_core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// cpu and flash engine at the far side of the guard
// ---------------------------------------------------------------
module bfg_core_model
  import bfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [13:0] cmd_pc,
  input  wire logic [13:0] cmd_addr,
  input  wire logic        force_bad,
  input  wire logic        re_done,
  input  wire logic [7:0]  done_dly,
  input  wire logic        prog_start,
  input  wire logic [13:0] prog_addr,
  output logic             flash_done,
  output logic [13:0]      pc_addr,
  output logic             acc_valid,
  output logic             acc_store,
  output logic [13:0]      acc_addr,
  output logic             fetch_valid,
  output logic [13:0]      fetch_addr,
  output logic             irq_req
);
  logic       hold_off;
  logic       run;
  logic [7:0] cnt;
  logic       ok;

  // software stays off the concurrent region until it re-enabled reads
  assign ok = force_bad || !hold_off || cmd_addr >= HALT_REGION_LO;

  always_ff @(posedge clk)
  begin
    pc_addr     <= cmd_pc;
    acc_store   <= cmd_kind == 2'd1;
    // idle address lines wander so stale values never look valid
    acc_addr    <= cmd_valid ? cmd_addr : ~acc_addr;
    fetch_addr  <= cmd_valid ? cmd_addr : ~fetch_addr;
    if (!rst_n)
    begin
      acc_valid   <= 1'b0;
      fetch_valid <= 1'b0;
      irq_req     <= 1'b0;
      flash_done  <= 1'b0;
      run         <= 1'b0;
      cnt         <= 8'h00;
      hold_off    <= 1'b0;
    end
    else
    begin
      acc_valid   <= cmd_valid && (cmd_kind == 2'd1 || (cmd_kind == 2'd0 && ok));
      fetch_valid <= cmd_valid && cmd_kind == 2'd2 && ok;
      irq_req     <= cmd_valid && cmd_kind == 2'd3 && (force_bad || !hold_off);
      flash_done  <= run && cnt == 8'h01;
      if (run && cnt == 8'h01)
        run <= 1'b0;
      if (run)
        cnt <= cnt - 8'h01;
      if (prog_start)
      begin
        run      <= 1'b1;
        cnt      <= done_dly;
        hold_off <= hold_off || prog_addr < HALT_REGION_LO;
      end
      if (re_done)
        hold_off <= 1'b0;
    end
  end
endmodule // bfg_core_model

// file: dv/test_boot_flash_access_guard.sv
`timescale 1ns/1ps
module test_boot_flash_access_guard;
  import bfg_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, rst_sel = 1'b1, gl_w = 1'b0, gl_rw = 1'b0;
  logic [1:0]  size = 2'b00;
  logic        cmd_valid = 1'b0, force_bad = 1'b0, re_done = 1'b0, vil = 1'b0;
  logic [1:0]  cmd_kind = 2'd0;
  logic [13:0] cmd_pc = 14'h0000, cmd_addr = 14'h0000, lo, ao;
  logic [7:0]  done_dly = 8'h01, note;
  logic        flash_done, acc_valid, acc_store, fetch_valid, irq_req, acc_grant, acc_deny;
  logic        fetch_grant, prog_start, cpu_halt, irq_out;
  logic [13:0] pc_addr, acc_addr, fetch_addr, prog_addr, reset_vector;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pend = 1'b0;
  logic [1:0]  bresp, rresp, am, lm;
  logic [33:0] axi_q[$];
  logic [7:0]  cpu_q[$];
  logic [1:0]  modes[4] = '{LOCK_M1, LOCK_M2, LOCK_M3, LOCK_M4};
  logic [13:0] lo_tab[4] = '{LOADER_LO_0, LOADER_LO_1, LOADER_LO_2, LOADER_LO_3};
  int          errors = 0, checks = 0, seed = 32'h3875;

  always #10 clk = ~clk;

  bfg_core_model core_u (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_pc(cmd_pc), .cmd_addr(cmd_addr), .force_bad(force_bad), .re_done(re_done),
    .done_dly(done_dly), .prog_start(prog_start), .prog_addr(prog_addr), .flash_done(flash_done),
    .pc_addr(pc_addr), .acc_valid(acc_valid), .acc_store(acc_store), .acc_addr(acc_addr),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .irq_req(irq_req));

  bfg_guard dut_u (.clk(clk), .rst_n(rst_n), .boot_reset_select_fuse(rst_sel), .boot_size_fuses(size),
    .general_lock_write(gl_w), .general_lock_rw(gl_rw), .pc_addr(pc_addr), .acc_valid(acc_valid),
    .acc_store(acc_store), .acc_addr(acc_addr), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .vectors_in_loader(vil), .irq_req(irq_req), .flash_done(flash_done), .acc_grant(acc_grant),
    .acc_deny(acc_deny), .fetch_grant(fetch_grant), .prog_start(prog_start), .prog_addr(prog_addr),
    .cpu_halt(cpu_halt), .irq_out(irq_out), .reset_vector(reset_vector), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // answers come one cycle after the request that the guard took
  always @(posedge clk)
  begin
    if (pend)
    begin
      note = cpu_q.pop_front();
      check("cpu", 34'({acc_grant, acc_deny, fetch_grant, irq_out} & note[7:4]), 34'(note[3:0]));
    end
    pend <= acc_valid | fetch_valid | irq_req;
    if (rvalid && rready)
      check("read", {rresp, rdata}, axi_q.pop_front());
    if (bvalid && bready)
      check("write", {bresp, 32'h0}, axi_q.pop_front());
  end

  initial
  begin
    #(20 * 20000);
    errors++;
    close_out();
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    axi_q.push_back({r, 32'h0});
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // only the watchdog ends a hung wait
    while (awvalid || wvalid || !bvalid)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    axi_q.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (arvalid || !rvalid)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // kind 0 load, 1 store, 2 fetch, 3 interrupt; note is {mask, expected}
  task automatic cpu(input logic [1:0] k, input logic [13:0] pc, input logic [13:0] a, input logic [7:0] n);
    if (n[7:4] != 4'h0)
      cpu_q.push_back(n);
    cmd_kind  <= k;
    cmd_pc    <= pc;
    cmd_addr  <= a;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic re_clear();
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    re_done <= 1'b1;
    @(posedge clk);
    re_done <= 1'b0;
    axi_rd(REG_STATUS, {RESP_OKAY, 32'h0});
  endtask

  task automatic st(input logic [13:0] pc, input logic [13:0] a, input logic ok);
    cpu(2'd1, pc, a, {4'b1100, ok, !ok, 2'b00});
    while (ok && !flash_done)
      @(posedge clk);
    if (ok && a < HALT_REGION_LO)
      axi_rd(REG_STATUS, {RESP_OKAY, 32'h1});
    re_clear();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    size    = 2'($random(seed));
    rst_sel = 1'($random(seed));
    lo      = lo_tab[size];
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("reset_vector", 34'(reset_vector), 34'(rst_sel ? APP_RESET_ADDR : lo));
    axi_rd(REG_STATUS, {RESP_OKAY, 32'h0});
    axi_rd(REG_LOCK, {RESP_OKAY, 32'h0f00});
    axi_wr(REG_FUSE, 32'h0, RESP_SLVERR);
    axi_rd(REG_FUSE, {RESP_OKAY, 29'h0, size, rst_sel});
    axi_wr(8'h10, 32'h0, RESP_DECERR);
    axi_rd(8'h10, {RESP_DECERR, 32'h0});
    for (int i = 0; i < 4; i++)
    begin
      am     = modes[i];
      lm     = modes[3 - i];
      ao     = {3'b000, 11'($random(seed))};
      gl_w   <= am[0];
      gl_rw  <= lm[0];
      cmd_pc <= lo;
      repeat (2) @(posedge clk);
      axi_wr(REG_CTRL, 32'hc, RESP_OKAY);
      axi_wr(REG_CTRL, {20'h0, lm, am, 8'h02}, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h0f02, RESP_OKAY);
      axi_rd(REG_LOCK, {RESP_OKAY, 20'h0, lm, am, 8'h00});
      cpu(2'd0, lo, ao, {4'b1100, am[1], !am[1], 2'b00});
      cpu(2'd0, 14'h0010, lo, {4'b1100, lm[1], !lm[1], 2'b00});
      cpu(2'd0, 14'h0010, lo - 14'd1, 8'hc8);
      vil <= 1'b0;
      cpu(2'd3, lo, 14'h0, {7'h08, lm[1]});
      cpu(2'd3, ao, 14'h0, 8'h11);
      vil <= 1'b1;
      cpu(2'd3, ao, 14'h0, {7'h08, am[1]});
      st(lo, ao, am[0]);
      st(lo, lo + 14'h20, lm[0]);
      cpu(2'd1, 14'h0010, ao, 8'hc4);
      axi_rd(REG_STATUS, {RESP_OKAY, 32'h0});
    end
    // slow engine so the blocked window can be probed from inside
    done_dly <= 8'd40;
    cpu(2'd1, lo, 14'h0200, 8'hc8);
    check("prog_addr", 34'(prog_addr), 34'h0200);
    cpu(2'd2, lo, lo + 14'h4, 8'h22);
    force_bad <= 1'b1;
    cpu(2'd2, lo, 14'h0010, 8'h20);
    axi_rd(REG_STATUS, {RESP_OKAY, 32'h5});
    wait (flash_done);
    @(posedge clk);
    axi_rd(REG_STATUS, {RESP_OKAY, 32'h1});
    cpu(2'd2, lo, 14'h0010, 8'h20);
    force_bad <= 1'b0;
    re_clear();
    cpu(2'd2, lo, 14'h0010, 8'h22);
    cpu(2'd1, lo, lo, 8'hc8);
    check("halt", 34'(cpu_halt), 34'h1);
    cpu(2'd2, lo, lo + 14'h4, 8'h20);
    wait (flash_done);
    repeat (2) @(posedge clk);
    check("halt", 34'(cpu_halt), 34'h0);
    re_clear();
    close_out();
  end
endmodule // test_boot_flash_access_guard
